// [rtl/anpa_regs.sv]
`timescale 1ns/10ps
module anpa_regs
    import anpa_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // AXI4-Lite write.
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read.
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Link side.
    input wire logic link_up_i,
    input wire logic page_valid_i,
    input wire logic [15:0] page_word_i,
    // Negotiation outputs.
    output logic [1:0] adv10_o,
    output logic [4:0] adv_sel_o,
    output logic [1:0] adv_gig_o,
    output logic an_active_o,
    output logic irq_o
);
    typedef struct packed {
        logic aw_ok;
        logic [ADDR_W-1:0] aw_addr;
        logic w_ok;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [5:0] ctrl;
        logic [1:0] adv10_pend;
        logic [1:0] adv10_live;
        logic [4:0] sel;
        logic [1:0] gig_adv;
        logic [15:0] partner;
        logic [EVT_W-1:0] irq_stat;
        logic [EVT_W-1:0] irq_mask;
        logic irq;
        logic [1:0] adv_out;
        logic [1:0] gig_out;
        logic an_act;
    } anpa_regs_type;
    anpa_regs_type st_reg, st_next;

    anpa_ev_if ev_bus();

    anpa_trigger u_trig (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .sw_reset_i(st_reg.ctrl[CTL_SWRST_BIT]),
        .restart_i(st_reg.ctrl[CTL_RESTART_BIT]),
        .pwrdn_i(st_reg.ctrl[CTL_PWRDN_BIT]),
        .link_up_i(link_up_i),
        .ev(ev_bus.src)
    );

    function automatic logic [7:0] word_addr(input logic [ADDR_W-1:0] a);
        return {a[7:2], 2'h0};
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        return a == ADDR_ADVERT || a == ADDR_PARTNER || a == ADDR_CTRL || a == ADDR_STAT
            || a == ADDR_IRQ_STAT || a == ADDR_IRQ_MASK || a == ADDR_GIG_ADV;
    endfunction

    logic forced_gig;
    logic do_write;
    logic do_read;
    logic [7:0] wa;
    logic [7:0] ra;
    logic [EVT_W-1:0] events;

    always_comb begin
        st_next = st_reg;
        wa = word_addr(st_reg.aw_addr);
        ra = word_addr(s_axi_araddr);
        do_write = st_reg.aw_ok && st_reg.w_ok && !st_reg.bvalid;
        do_read = s_axi_arvalid && !st_reg.rvalid;
        events = '0;
        // Self-clearing strobes last one cycle.
        st_next.ctrl[CTL_SWRST_BIT] = 1'b0;
        st_next.ctrl[CTL_RESTART_BIT] = 1'b0;

        if (s_axi_awvalid && !st_reg.aw_ok) begin
            st_next.aw_ok = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_reg.w_ok) begin
            st_next.w_ok = 1'b1;
            st_next.w_data = s_axi_wdata;
            st_next.w_strb = s_axi_wstrb;
        end

        if (do_write) begin
            st_next.aw_ok = 1'b0;
            st_next.w_ok = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = is_mapped(wa) ? AXI_OKAY : AXI_SLVERR;
            if (st_reg.w_strb[0]) begin
                case (wa)
                    ADDR_CTRL: st_next.ctrl = st_reg.w_data[5:0];
                    ADDR_ADVERT: begin
                        st_next.adv10_pend = st_reg.w_data[ADV_FD10_BIT:ADV_HD10_BIT];
                        st_next.sel = st_reg.w_data[4:0];
                    end
                    ADDR_IRQ_MASK: st_next.irq_mask = st_reg.w_data[EVT_W-1:0];
                    ADDR_GIG_ADV: st_next.gig_adv = st_reg.w_data[1:0];
                    default: st_next.bresp = st_next.bresp;
                endcase
            end
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end

        if (do_read) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = is_mapped(ra) ? AXI_OKAY : AXI_SLVERR;
            case (ra)
                ADDR_CTRL: st_next.rdata = {26'h0000000, st_reg.ctrl};
                ADDR_STAT: st_next.rdata = {27'h0000000, st_reg.adv10_pend != st_reg.adv10_live,
                    st_reg.an_act, st_reg.gig_out, link_up_i};
                ADDR_ADVERT: st_next.rdata = {25'h0000000, st_reg.adv10_live, st_reg.sel};
                ADDR_PARTNER: st_next.rdata = {16'h0000, st_reg.partner};
                ADDR_IRQ_STAT: st_next.rdata = {30'h00000000, st_reg.irq_stat};
                ADDR_IRQ_MASK: st_next.rdata = {30'h00000000, st_reg.irq_mask};
                ADDR_GIG_ADV: st_next.rdata = {30'h00000000, st_reg.gig_adv};
                default: st_next.rdata = 32'h00000000;
            endcase
        end
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end

        if (ev_bus.apply) begin
            st_next.adv10_live = st_reg.adv10_pend;
            events[EVT_APPLY_BIT] = 1'b1;
        end

        if (page_valid_i) begin
            st_next.partner[15] = page_word_i[15];
            st_next.partner[14] = page_word_i[14];
            st_next.partner[13] = page_word_i[13];
            st_next.partner[12] = page_word_i[12];
            st_next.partner[11] = page_word_i[11];
            st_next.partner[10] = page_word_i[10];
            st_next.partner[9] = page_word_i[9];
            st_next.partner[8:7] = page_word_i[8:7];
            st_next.partner[6:5] = page_word_i[6:5];
            st_next.partner[4:0] = page_word_i[4:0];
            events[EVT_PAGE_BIT] = 1'b1;
        end
        if (ev_bus.sw_reset) begin
            st_next.partner = 16'h0000;
        end

        // Read clears status, but an event in the same cycle still sets it.
        if (do_read && ra == ADDR_IRQ_STAT) begin
            st_next.irq_stat = '0;
        end
        st_next.irq_stat = st_next.irq_stat | events;
        st_next.irq = |(st_next.irq_stat & st_next.irq_mask);

        forced_gig = !st_next.ctrl[CTL_AN_EN_BIT] && st_next.ctrl[CTL_FORCE1000_BIT];
        if (forced_gig) begin
            st_next.adv_out = 2'h0;
            st_next.gig_out = st_next.ctrl[CTL_DUPLEX_BIT] ? 2'h2 : 2'h1;
        end else begin
            st_next.adv_out = st_next.adv10_live;
            st_next.gig_out = st_next.gig_adv;
        end
        st_next.an_act = st_next.ctrl[CTL_AN_EN_BIT] || forced_gig;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
            st_reg.adv10_pend <= ADV10_RESET;
            st_reg.adv10_live <= ADV10_RESET;
            st_reg.adv_out <= ADV10_RESET;
            st_reg.sel <= SEL_IEEE;
            st_reg.ctrl <= CTL_RESET;
            st_reg.an_act <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign s_axi_awready = !st_reg.aw_ok;
    assign s_axi_wready = !st_reg.w_ok;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = !st_reg.rvalid;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;
    assign adv10_o = st_reg.adv_out;
    assign adv_sel_o = st_reg.sel;
    assign adv_gig_o = st_reg.gig_out;
    assign an_active_o = st_reg.an_act;
    assign irq_o = st_reg.irq;

    a_pending_held: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !ev_bus.apply |=> st_reg.adv10_live == $past(st_reg.adv10_live))
        else $error("Advertisement changed without a trigger.");
    a_apply_takes: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ev_bus.apply |=> st_reg.adv10_live == $past(st_reg.adv10_pend))
        else $error("Pending advertisement not applied.");
    a_forced_gig: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (!st_reg.ctrl[CTL_AN_EN_BIT] && st_reg.ctrl[CTL_FORCE1000_BIT])
        |-> adv10_o == 2'h0 && adv_gig_o == (st_reg.ctrl[CTL_DUPLEX_BIT] ? 2'h2 : 2'h1))
        else $error("Forced gigabit advertisement wrong.");
    a_sel_keep: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ev_bus.sw_reset && !do_write |=> adv_sel_o == $past(adv_sel_o))
        else $error("Selector lost on software reset.");
    a_page_load: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        page_valid_i && !ev_bus.sw_reset |=> st_reg.partner == $past(page_word_i))
        else $error("Partner register not loaded from page.");
    a_partner_clr: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ev_bus.sw_reset |=> st_reg.partner == 16'h0000)
        else $error("Partner register not cleared.");
    a_an_active: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        st_reg.ctrl[CTL_FORCE1000_BIT] |-> an_active_o)
        else $error("Gigabit forced without negotiation.");
    // A mask write in the same cycle may legally withdraw the page event, so it is left out.
    a_irq_page: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        page_valid_i && st_reg.irq_mask[EVT_PAGE_BIT] && !do_write |=> irq_o)
        else $error("Received page did not raise the interrupt.");
    a_adv_reset: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $rose(rst_n_i) |-> adv10_o == ADV10_RESET && st_reg.adv10_pend == ADV10_RESET)
        else $error("Advertisement not both modes after reset.");
    c_apply: cover property (@(posedge mclk_i) disable iff (!rst_n_i) ev_bus.apply);
    c_page: cover property (@(posedge mclk_i) disable iff (!rst_n_i) page_valid_i ##2 s_axi_rvalid);
    c_forced: cover property (@(posedge mclk_i) disable iff (!rst_n_i) st_reg.gig_out == 2'h2);
endmodule // anpa_regs

// [inc/anpa_pkg.sv]
package anpa_pkg;
    // AXI4-Lite byte addresses of the register words.
    localparam logic [7:0] ADDR_ADVERT = 8'h10;
    localparam logic [7:0] ADDR_PARTNER = 8'h14;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_GIG_ADV = 8'h18;
    // Advertisement field layout.
    localparam int ADV_FD10_BIT = 6;
    localparam int ADV_HD10_BIT = 5;
    localparam logic [4:0] SEL_IEEE = 5'h01;
    localparam logic [1:0] ADV10_RESET = 2'h3;
    // Control register bits.
    localparam int CTL_SWRST_BIT = 0;
    localparam int CTL_RESTART_BIT = 1;
    localparam int CTL_AN_EN_BIT = 2;
    localparam int CTL_FORCE1000_BIT = 3;
    localparam int CTL_DUPLEX_BIT = 4;
    localparam int CTL_PWRDN_BIT = 5;
    localparam logic [5:0] CTL_RESET = 6'h04;
    // Interrupt events: bit 0 page received, bit 1 advertisement applied.
    localparam int EVT_PAGE_BIT = 0;
    localparam int EVT_APPLY_BIT = 1;
    localparam int EVT_W = 2;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// [inc/anpa_ev_if.sv]
`timescale 1ns/10ps
// Apply events from the trigger detector to the register bank.
interface anpa_ev_if;
    logic apply;
    logic sw_reset;
    modport src (output apply, output sw_reset);
    modport dst (input apply, input sw_reset);
endinterface

// [rtl/anpa_trigger.sv]
`timescale 1ns/10ps
module anpa_trigger
    import anpa_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Raw conditions.
    input wire logic sw_reset_i,
    input wire logic restart_i,
    input wire logic pwrdn_i,
    input wire logic link_up_i,
    // Event output.
    anpa_ev_if.src ev
);
    typedef struct packed {
        logic pwrdn;
        logic link;
    } anpa_trig_type;
    anpa_trig_type st_reg, st_next;

    always_comb begin
        st_next.pwrdn = pwrdn_i;
        st_next.link = link_up_i;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign ev.apply = sw_reset_i | restart_i | (st_reg.pwrdn & ~pwrdn_i) | (st_reg.link & ~link_up_i);
    assign ev.sw_reset = sw_reset_i;
endmodule // anpa_trigger

// [sim/anpa_link_partner.sv]
`timescale 1ns/10ps
module anpa_link_partner (
    // Clock.
    input wire logic mclk_i,
    // Link side.
    output logic link_up_o,
    output logic page_valid_o,
    output logic [15:0] page_word_o
);
    logic send_req;
    logic [15:0] send_word;

    initial begin
        link_up_o = 1'b1;
        page_valid_o = 1'b0;
        page_word_o = 16'hA5A5;
        send_req = 1'b0;
        send_word = 16'h0;
    end

    // The word toggles between pages so a stale value is never mistaken for a fresh one.
    always @(posedge mclk_i) begin
        page_valid_o <= send_req;
        page_word_o <= send_req ? send_word : ~page_word_o;
    end

    task automatic send_page(input logic [15:0] w);
        send_word <= w;
        send_req <= 1'b1;
        @(posedge mclk_i);
        send_req <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic set_link(input logic up);
        link_up_o <= up;
    endtask
endmodule // anpa_link_partner

// [sim/tb.sv]
`timescale 1ns/10ps
module tb;
    import anpa_pkg::*;
    logic mclk_i, rst_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rnd;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, adv10_o, adv_gig_o, v, prev;
    logic link_up_i, page_valid_i, an_active_o, irq_o;
    logic [15:0] page_word_i;
    logic [4:0] adv_sel_o;
    logic [10:0] outs;
    logic [33:0] exp_q[$];
    int err_count, comparisons;
    integer seed;

    assign outs = {irq_o, an_active_o, adv_gig_o, adv10_o, adv_sel_o};

    anpa_regs dut (.mclk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .link_up_i, .page_valid_i, .page_word_i, .adv10_o, .adv_sel_o, .adv_gig_o,
        .an_active_o, .irq_o);

    anpa_link_partner partner (.mclk_i(mclk_i), .link_up_o(link_up_i), .page_valid_o(page_valid_i),
        .page_word_o(page_word_i));

    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    task automatic conclude();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic step(inout int k);
        @(posedge mclk_i);
        k++;
        if (k > 50) begin
            err_count++;
            conclude();
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        bit done;
        k = 0;
        done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            step(k);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bready <= 1'b0;
                check({32'h0, s_axi_bresp}, {32'h0, er});
                done = 1'b1;
            end
        end
        @(posedge mclk_i);
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [33:0] exp);
        int k;
        bit done;
        k = 0;
        done = 1'b0;
        exp_q.push_back(exp);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            step(k);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
        @(posedge mclk_i);
    endtask

    // Outputs may lag the cause by a pipeline stage, so allow a short settling window.
    task automatic wait_outs(input logic [10:0] exp, input logic [10:0] care);
        int k;
        k = 0;
        while (((outs & care) !== (exp & care)) && k < 12) begin
            @(posedge mclk_i);
            k++;
        end
        check({23'h0, outs & care}, {23'h0, exp & care});
    endtask

    always @(posedge mclk_i) begin
        if (s_axi_rvalid && s_axi_rready) begin
            if (exp_q.size() == 0) begin
                check({s_axi_rresp, s_axi_rdata}, 34'h3FFFFFFFF);
            end else begin
                check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
            end
        end
    end

    initial begin
        seed = 32'hD8EBE00B;
        rst_n_i = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        repeat (5) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        axi_rd(ADDR_ADVERT, {AXI_OKAY, 32'h00000061});
        axi_rd(ADDR_PARTNER, {AXI_OKAY, 32'h0});
        axi_rd(8'h1C, {AXI_SLVERR, 32'h0});
        axi_wr(8'h1C, 32'h0, AXI_SLVERR);
        axi_wr(ADDR_IRQ_MASK, 32'h3, AXI_OKAY);
        for (int i = 0; i < 8; i++) begin
            rnd = (i == 0) ? 32'hFFFF : $random(seed);
            partner.send_page(rnd[15:0]);
            axi_rd(ADDR_PARTNER, {AXI_OKAY, 16'h0, rnd[15:0]});
        end
        wait_outs(11'h400, 11'h400);
        axi_wr(ADDR_IRQ_MASK, 32'h2, AXI_OKAY);
        wait_outs(11'h000, 11'h400);
        axi_wr(ADDR_IRQ_MASK, 32'h1, AXI_OKAY);
        wait_outs(11'h400, 11'h400);
        axi_rd(ADDR_IRQ_STAT, {AXI_OKAY, 32'h1});
        wait_outs(11'h000, 11'h400);
        prev = 2'h3;
        for (int t = 0; t < 4; t++) begin
            v = t[1:0] ^ 2'h1;
            axi_wr(ADDR_ADVERT, {25'h0, v, 5'h1F}, AXI_OKAY);
            axi_rd(ADDR_ADVERT, {AXI_OKAY, 25'h0, prev, 5'h1F});
            wait_outs({4'h0, prev, 5'h1F}, 11'h07F);
            case (t)
                0: axi_wr(ADDR_CTRL, 32'h06, AXI_OKAY);
                1: partner.set_link(1'b0);
                2: begin
                    axi_wr(ADDR_CTRL, 32'h24, AXI_OKAY);
                    axi_wr(ADDR_CTRL, 32'h04, AXI_OKAY);
                end
                default: axi_wr(ADDR_CTRL, 32'h05, AXI_OKAY);
            endcase
            wait_outs({4'h0, v, 5'h1F}, 11'h07F);
            partner.set_link(1'b1);
            prev = v;
        end
        axi_rd(ADDR_PARTNER, {AXI_OKAY, 32'h0});
        // Both gigabit modes are advertised here, so the forced mode must visibly override them.
        axi_wr(ADDR_GIG_ADV, 32'h3, AXI_OKAY);
        axi_wr(ADDR_CTRL, 32'h1A, AXI_OKAY);
        wait_outs(11'h300, 11'h3E0);
        axi_wr(ADDR_CTRL, 32'h0A, AXI_OKAY);
        wait_outs(11'h280, 11'h3E0);
        axi_wr(ADDR_CTRL, 32'h04, AXI_OKAY);
        wait_outs(11'h3DF, 11'h7FF);
        // A hardware reset in mid-run must restore the defaults and drop the stored page.
        partner.send_page(16'h5A5A);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        wait_outs(11'h261, 11'h7FF);
        axi_rd(ADDR_ADVERT, {AXI_OKAY, 32'h00000061});
        axi_rd(ADDR_PARTNER, {AXI_OKAY, 32'h0});
        conclude();
    end
endmodule // tb
